// >>> hw/ccd_pkg.sv
// Summary of operation
// - Take raw samples at 200 MS/s; raise trigger request for neutron pulses.
// - Main controller FSM enables each unit in a fixed sequence per settings.
// - Eighth order moving average smooths samples before threshold detection.
// - Threshold detector gives one pulse when filtered signal crosses level.
// - Recursive slow, fast, baseline integrals; baseline is 32 pre-trigger samples.
// - Fast sums samples 1..alpha, slow sums alpha+1..beta after start.
// - Each integrator raises a done flag when its accumulation ends.
// - Match unit waits for all done flags, then starts correction.
// - Corrected slow = slow - beta*mean; corrected fast = fast - alpha*mean.
// - Neutron when corrected slow at least delta times corrected fast.
// - Six parallel-in serial-out registers hold results and settings for serial readout.
// - Corrected fast is scaled by power of two so delta is an integer.
package ccd_pkg;
   // Register byte offsets
   localparam logic [7:0]  CCD_CTRL_OFS   = 8'h00;
   localparam logic [7:0]  CCD_THR_OFS    = 8'h04;
   localparam logic [7:0]  CCD_ALPHA_OFS  = 8'h08;
   localparam logic [7:0]  CCD_BETA_OFS   = 8'h0C;
   localparam logic [7:0]  CCD_DELTA_OFS  = 8'h10;
   localparam logic [7:0]  CCD_SHIFT_OFS  = 8'h14;
   localparam logic [7:0]  CCD_STAT_OFS   = 8'h18;
   localparam logic [7:0]  CCD_MASK_OFS   = 8'h1C;
   localparam logic [7:0]  CCD_COUNT_OFS  = 8'h20;
   // Reset values
   localparam logic [13:0] CCD_THR_RST    = 14'h0100;
   localparam logic [7:0]  CCD_ALPHA_RST  = 8'h05;
   localparam logic [7:0]  CCD_BETA_RST   = 8'h64;
   localparam logic [7:0]  CCD_DELTA_RST  = 8'h04;
   localparam logic [3:0]  CCD_SHIFT_RST  = 4'h4;
   // Status bit positions
   localparam int          CCD_ST_TRIG    = 0;
   localparam int          CCD_ST_GAMMA   = 1;
   localparam int          CCD_ST_NSTAT   = 2;
   // Filter and baseline
   localparam int          CCD_MA_ORDER   = 8;
   localparam int          CCD_MA_SHIFT   = 3;
   localparam int          CCD_BL_LEN     = 32;
   localparam int          CCD_BL_SHIFT   = 5;
   localparam int          CCD_PISO_NUM   = 6;
   // Sample rate and clock
   localparam int          CCD_SAMPLE_MSPS = 200;
   localparam int          CCD_CLK_MHZ    = 25;
   typedef enum logic [4:0] {
      CCD_IDLE  = 5'b00001,
      CCD_INTEG = 5'b00010,
      CCD_MATCH = 5'b00100,
      CCD_CORR  = 5'b01000,
      CCD_DISC  = 5'b10000
   } ccd_state_type;
endpackage : ccd_pkg

// >>> hw/ccd_piso.sv
`timescale 1ns/1ns
// Parallel-in serial-out register, MSB first
module ccd_piso #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   input  wire logic             load_in,
   input  wire logic             shift_in,
   input  wire logic [WIDTH-1:0] data_in,
   output logic                  ser_out
);
   logic [WIDTH-1:0] sh_r;
   // Load wins over shift
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         sh_r <= '0;
      end
      else if (load_in)
      begin
         sh_r <= data_in;
      end
      else if (shift_in)
      begin
         sh_r <= {sh_r[WIDTH-2:0], 1'b0};
      end
   end
   assign ser_out = sh_r[WIDTH-1];
endmodule : ccd_piso

// >>> hw/ccd_top.sv
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
// Charge-comparison neutron/gamma discriminator with APB set-up registers
module ccd_top #(
   parameter int SW = 14,
   parameter int IW = 32
) (
   input  wire logic          clk_in,
   input  wire logic          reset_in,
   input  wire logic [SW-1:0] sample_in,
   input  wire logic          sample_valid_in,
   input  wire logic          piso_shift_in,
   input  wire logic [7:0]    paddr_in,
   input  wire logic          psel_in,
   input  wire logic          penable_in,
   input  wire logic          pwrite_in,
   input  wire logic [31:0]   pwdata_in,
   output logic [31:0]        prdata_out,
   output logic               pready_out,
   output logic               pslverr_out,
   output logic               trig_req_out,
   output logic [5:0]         piso_ser_out,
   output logic               irq_out
);
   import ccd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [31:0]        ctrl_r;
   logic [SW-1:0]      thr_r;
   logic [7:0]         alpha_r;
   logic [7:0]         beta_r;
   logic [7:0]         delta_r;
   logic [3:0]         shift_r;
   logic [CCD_ST_NSTAT-1:0] stat_r;
   logic [CCD_ST_NSTAT-1:0] mask_r;
   logic [15:0]        count_r;
   logic               enable;
   logic               acc;
   logic               rd_stat;
   logic [SW-1:0]      ma_dly_r [CCD_MA_ORDER];
   logic [SW+2:0]      ma_sum_r;
   logic [SW-1:0]      ma_val;
   logic               above_r;
   logic               thr_hit;
   logic [SW-1:0]      bl_dly_r [CCD_BL_LEN];
   logic [SW+4:0]      bl_sum_r;
   logic [IW-1:0]      ib_r;
   logic [IW-1:0]      if_r;
   logic [IW-1:0]      is_r;
   logic [7:0]         idx_r;
   logic               f_done_r;
   logic               s_done_r;
   logic               b_done_r;
   logic signed [IW+1:0] cs_r;
   logic signed [IW+1:0] cf_r;
   logic signed [IW+11:0] lhs;
   logic signed [IW+11:0] rhs;
   logic               neutron_evt;
   logic               gamma_evt;
   logic               piso_load_r;
   ccd_state_type      state_r;
   ccd_state_type      state_nxt;

   assign enable = ctrl_r[0];
   assign acc    = psel_in & penable_in;

   ////////////////////////////////////////////////////////////////////////
   // APB register writes, software loads parameters
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         ctrl_r  <= 32'h0000_0000;
         thr_r   <= CCD_THR_RST;
         alpha_r <= CCD_ALPHA_RST;
         beta_r  <= CCD_BETA_RST;
         delta_r <= CCD_DELTA_RST;
         shift_r <= CCD_SHIFT_RST;
         mask_r  <= '0;
      end
      else if (acc && pwrite_in)
      begin
         case (paddr_in)
            CCD_CTRL_OFS:  ctrl_r  <= pwdata_in;
            CCD_THR_OFS:   thr_r   <= pwdata_in[SW-1:0];
            CCD_ALPHA_OFS: alpha_r <= pwdata_in[7:0];
            CCD_BETA_OFS:  beta_r  <= pwdata_in[7:0];
            CCD_DELTA_OFS: delta_r <= pwdata_in[7:0];
            CCD_SHIFT_OFS: shift_r <= pwdata_in[3:0];
            CCD_MASK_OFS:  mask_r  <= pwdata_in[CCD_ST_NSTAT-1:0];
            default:       ctrl_r  <= ctrl_r;
         endcase
      end
   end

   // Read data and zero-wait answer, error on unmapped address
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         prdata_out  <= 32'h0000_0000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end
      else
      begin
         pready_out  <= psel_in & ~penable_in;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
         if (psel_in && !penable_in)
         begin
            case (paddr_in)
               CCD_CTRL_OFS:  prdata_out <= ctrl_r;
               CCD_THR_OFS:   prdata_out <= {{(32-SW){1'b0}}, thr_r};
               CCD_ALPHA_OFS: prdata_out <= {24'h00_0000, alpha_r};
               CCD_BETA_OFS:  prdata_out <= {24'h00_0000, beta_r};
               CCD_DELTA_OFS: prdata_out <= {24'h00_0000, delta_r};
               CCD_SHIFT_OFS: prdata_out <= {28'h000_0000, shift_r};
               CCD_STAT_OFS:  prdata_out <= {30'h0000_0000, stat_r};
               CCD_MASK_OFS:  prdata_out <= {30'h0000_0000, mask_r};
               CCD_COUNT_OFS: prdata_out <= {16'h0000, count_r};
               default:       pslverr_out <= 1'b1;
            endcase
         end
      end
   end

   assign rd_stat = acc && !pwrite_in && paddr_in == CCD_STAT_OFS;

   // Sticky events, read clears, set beats clear
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         stat_r <= '0;
      end
      else
      begin
         stat_r <= (rd_stat ? '0 : stat_r)
                   | {gamma_evt, neutron_evt};
      end
   end

   // Level interrupt from unmasked status
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         irq_out <= 1'b0;
      end
      else
      begin
         irq_out <= |(stat_r & mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Eighth order moving average, one sample per valid
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         for (int i = 0; i < CCD_MA_ORDER; i++)
         begin
            ma_dly_r[i] <= '0;
         end
         ma_sum_r <= '0;
      end
      else if (sample_valid_in)
      begin
         ma_dly_r[0] <= sample_in;
         for (int i = 1; i < CCD_MA_ORDER; i++)
         begin
            ma_dly_r[i] <= ma_dly_r[i-1];
         end
         ma_sum_r <= ma_sum_r + (SW+3)'(sample_in)
                     - (SW+3)'(ma_dly_r[CCD_MA_ORDER-1]);
      end
   end

   assign ma_val = ma_sum_r[SW+2:CCD_MA_SHIFT];

   // Rising crossing of threshold gives a single pulse
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         above_r <= 1'b0;
      end
      else if (sample_valid_in)
      begin
         above_r <= ma_val >= thr_r;
      end
   end

   assign thr_hit = sample_valid_in && !above_r && ma_val >= thr_r;

   ////////////////////////////////////////////////////////////////////////
   // Running 32-sample baseline window, frozen at trigger
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         for (int i = 0; i < CCD_BL_LEN; i++)
         begin
            bl_dly_r[i] <= '0;
         end
         bl_sum_r <= '0;
      end
      else if (sample_valid_in)
      begin
         bl_dly_r[0] <= sample_in;
         for (int i = 1; i < CCD_BL_LEN; i++)
         begin
            bl_dly_r[i] <= bl_dly_r[i-1];
         end
         bl_sum_r <= bl_sum_r + (SW+5)'(sample_in)
                     - (SW+5)'(bl_dly_r[CCD_BL_LEN-1]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main controller sequence
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         CCD_IDLE:  if (enable && thr_hit) state_nxt = CCD_INTEG;
         CCD_INTEG: if (f_done_r && s_done_r) state_nxt = CCD_MATCH;
         CCD_MATCH: if (f_done_r && s_done_r && b_done_r)
                       state_nxt = CCD_CORR;
         CCD_CORR:  state_nxt = CCD_DISC;
         CCD_DISC:  state_nxt = CCD_IDLE;
         default:   state_nxt = CCD_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         state_r <= CCD_IDLE;
      end
      else
      begin
         state_r <= enable ? state_nxt : CCD_IDLE;
      end
   end

   // Recursive fast/slow/baseline integrators and done flags
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         ib_r     <= '0;
         if_r     <= '0;
         is_r     <= '0;
         idx_r    <= '0;
         f_done_r <= 1'b0;
         s_done_r <= 1'b0;
         b_done_r <= 1'b0;
      end
      else if (state_r == CCD_IDLE && enable && thr_hit)
      begin
         ib_r     <= IW'(bl_sum_r);
         b_done_r <= 1'b1;
         if_r     <= '0;
         is_r     <= '0;
         idx_r    <= 8'h01;
         f_done_r <= alpha_r == 8'h00;
         s_done_r <= beta_r <= alpha_r;
      end
      else if (state_r == CCD_INTEG && sample_valid_in)
      begin
         if (idx_r <= alpha_r)
         begin
            if_r <= if_r + IW'(sample_in);
         end
         else if (idx_r <= beta_r)
         begin
            is_r <= is_r + IW'(sample_in);
         end
         if (idx_r >= alpha_r)
         begin
            f_done_r <= 1'b1;
         end
         if (idx_r >= beta_r)
         begin
            s_done_r <= 1'b1;
         end
         idx_r <= idx_r + 8'h01;
      end
      else if (state_r == CCD_DISC)
      begin
         f_done_r <= 1'b0;
         s_done_r <= 1'b0;
         b_done_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pedestal correction with mean baseline by shift
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         cs_r <= '0;
         cf_r <= '0;
      end
      else if (state_r == CCD_MATCH && state_nxt == CCD_CORR)
      begin
         cs_r <= $signed({2'b00, is_r})
                 - $signed((IW+2)'(beta_r * (ib_r >> CCD_BL_SHIFT)));
         cf_r <= $signed({2'b00, if_r})
                 - $signed((IW+2)'(alpha_r * (ib_r >> CCD_BL_SHIFT)));
      end
   end

   // Scaled fast integral lets delta be an integer
   assign lhs = (IW+12)'(cs_r);
   assign rhs = ($signed({1'b0, delta_r}) * (IW+12)'(cf_r))
                <<< shift_r;
   assign neutron_evt = state_r == CCD_DISC && lhs >= rhs;
   assign gamma_evt   = state_r == CCD_DISC && lhs < rhs;

   // One-cycle trigger request and neutron count
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         trig_req_out <= 1'b0;
         count_r      <= 16'h0000;
         piso_load_r  <= 1'b0;
      end
      else
      begin
         trig_req_out <= neutron_evt;
         piso_load_r  <= state_r == CCD_CORR;
         if (neutron_evt)
         begin
            count_r <= count_r + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Six serial readout registers: IS, IF, IB, corrected IS, IF, settings
   ccd_piso #(.WIDTH(IW)) u_piso_s (.clk_in(clk_in), .reset_in(reset_in),
      .load_in(piso_load_r), .shift_in(piso_shift_in), .data_in(is_r),
      .ser_out(piso_ser_out[0]));
   ccd_piso #(.WIDTH(IW)) u_piso_f (.clk_in(clk_in), .reset_in(reset_in),
      .load_in(piso_load_r), .shift_in(piso_shift_in), .data_in(if_r),
      .ser_out(piso_ser_out[1]));
   ccd_piso #(.WIDTH(IW)) u_piso_b (.clk_in(clk_in), .reset_in(reset_in),
      .load_in(piso_load_r), .shift_in(piso_shift_in), .data_in(ib_r),
      .ser_out(piso_ser_out[2]));
   ccd_piso #(.WIDTH(IW)) u_piso_cs (.clk_in(clk_in), .reset_in(reset_in),
      .load_in(piso_load_r), .shift_in(piso_shift_in),
      .data_in(cs_r[IW-1:0]), .ser_out(piso_ser_out[3]));
   ccd_piso #(.WIDTH(IW)) u_piso_cf (.clk_in(clk_in), .reset_in(reset_in),
      .load_in(piso_load_r), .shift_in(piso_shift_in),
      .data_in(cf_r[IW-1:0]), .ser_out(piso_ser_out[4]));
   ccd_piso #(.WIDTH(IW)) u_piso_p (.clk_in(clk_in), .reset_in(reset_in),
      .load_in(piso_load_r), .shift_in(piso_shift_in),
      .data_in({alpha_r, beta_r, delta_r, 4'h0, shift_r}),
      .ser_out(piso_ser_out[5]));
endmodule : ccd_top

// >>> bench/ccd_chk.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
// Watches the register bus, the trigger request and the interrupt
module ccd_chk
   import ccd_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [31:0] prdata_out,
   input  wire logic        pready_out,
   input  wire logic        pslverr_out,
   input  wire logic        trig_req_out,
   input  wire logic        irq_out
);
   logic       en_r;
   logic [7:0] alpha_r;
   logic [7:0] beta_r;
   logic [1:0] mask_r;
   logic       wr_done;
   logic       rd_done;
   assign wr_done = psel_in && penable_in && pready_out && pwrite_in;
   assign rd_done = pready_out && !pwrite_in;
   // Shadow settings, taken at the edge that completes a write
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         en_r    <= 1'b0;
         alpha_r <= CCD_ALPHA_RST;
         beta_r  <= CCD_BETA_RST;
         mask_r  <= 2'b00;
      end
      else if (wr_done)
      begin
         if (paddr_in == CCD_CTRL_OFS) en_r <= pwdata_in[0];
         if (paddr_in == CCD_ALPHA_OFS) alpha_r <= pwdata_in[7:0];
         if (paddr_in == CCD_BETA_OFS) beta_r <= pwdata_in[7:0];
         if (paddr_in == CCD_MASK_OFS) mask_r <= pwdata_in[1:0];
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   trig_pulse_a: assert property (trig_req_out |=> !trig_req_out [*3])
      else $error("trigger request wider than one cycle");
   trig_enable_a: assert property (trig_req_out |-> en_r)
      else $error("trigger request while disabled");
   setup_ready_a: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no ready one cycle after setup");
   ready_access_a: assert property
      (pready_out |-> penable_in && $past(psel_in && !penable_in))
      else $error("ready outside an access cycle");
   unmapped_err_a: assert property (pready_out && paddr_in > 8'h20
      |-> pslverr_out && (pwrite_in || prdata_out == 32'h0))
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (pready_out && paddr_in <= 8'h20
      && paddr_in[1:0] == 2'b00 |-> !pslverr_out)
      else $error("mapped access refused");
   alpha_read_a: assert property
      (rd_done && paddr_in == CCD_ALPHA_OFS |-> prdata_out[7:0] == alpha_r)
      else $error("fast limit reads back wrong");
   beta_read_a: assert property
      (rd_done && paddr_in == CCD_BETA_OFS |-> prdata_out[7:0] == beta_r)
      else $error("slow limit reads back wrong");
   irq_mask_a: assert property
      (irq_out |-> mask_r != 2'b00 || $past(mask_r) != 2'b00)
      else $error("interrupt with every source masked");
   // Main scenarios
   cover property (trig_req_out);
   cover property (pready_out && pslverr_out);
   cover property (irq_out);
endmodule : ccd_chk

bind ccd_top ccd_chk u_ccd_chk (
   .clk_in(clk_in), .reset_in(reset_in), .paddr_in(paddr_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out),
   .trig_req_out(trig_req_out), .irq_out(irq_out)
);

// >>> bench/ccd_far_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
// Digitiser making flat-topped pulses, and a trigger leaf that counts
module ccd_far_model (
   input  wire logic        clk_in,
   input  wire logic        fire_in,
   input  wire logic [13:0] base_in,
   input  wire logic [13:0] top_in,
   input  wire logic        trig_req_in,
   output logic [13:0]      sample_out,
   output logic             sample_valid_out,
   output int               trig_count_out
);
   int left_r;
   // Quiet start until the first edge
   initial
   begin
      sample_out       = 14'h0;
      sample_valid_out = 1'b0;
      trig_count_out   = 0;
      left_r           = 0;
   end
   // One sample per clock; plateau of 160 samples outlasts the slow limits the test draws (90 to 110)
   always @(posedge clk_in)
   begin
      sample_valid_out <= 1'b1;
      left_r <= fire_in ? 160 : (left_r > 0 ? left_r - 1 : 0);
      sample_out <= (left_r > 0) ? top_in : base_in;
   end
   // Leaf stores every one-cycle request
   always @(posedge clk_in)
      if (trig_req_in) trig_count_out <= trig_count_out + 1;
endmodule : ccd_far_model

// >>> bench/testbench.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
module testbench;
   import ccd_pkg::*;
   logic        clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic [13:0] sample;
   logic        svalid;
   logic        pshift = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, trig, irq, err, n;
   logic [5:0]  ser;
   logic        fire = 1'b0;
   logic [13:0] base = 14'h0;
   logic [13:0] top = 14'h0;
   logic [31:0] rd;
   logic [31:0] lane [6];
   logic [7:0]  ofs [5] = '{CCD_THR_OFS, CCD_ALPHA_OFS, CCD_BETA_OFS,
                            CCD_DELTA_OFS, CCD_SHIFT_OFS};
   logic [31:0] rst [5] = '{32'(CCD_THR_RST), 32'(CCD_ALPHA_RST),
      32'(CCD_BETA_RST), 32'(CCD_DELTA_RST), 32'(CCD_SHIFT_RST)};
   int          bad_count = 0;
   int          checked = 0;
   int          seed = 5292;
   int          fired, alpha, beta, dl, shft;
   int          nexp = 0;
   int          mb;
   // 25 MHz clock
   always #20 clk_in = ~clk_in;
   ccd_top u_ccd_top (
      .clk_in(clk_in), .reset_in(reset_in), .sample_in(sample),
      .sample_valid_in(svalid), .piso_shift_in(pshift), .paddr_in(paddr),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .trig_req_out(trig), .piso_ser_out(ser),
      .irq_out(irq));
   ccd_far_model u_ccd_far_model (
      .clk_in(clk_in), .fire_in(fire), .base_in(base), .top_in(top),
      .trig_req_in(trig), .sample_out(sample), .sample_valid_out(svalid),
      .trig_count_out(fired));
   ////////////////////////////////////////////////////////////////////
   // Counts one comparison and reports a mismatch
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One bus transfer; waits for ready with a bound
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      @(posedge clk_in);
      while (pready !== 1'b1 && k < 20)
      begin
         k++;
         @(posedge clk_in);
      end
      if (k == 20) bad_count++;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_in);
   endtask : apb
   // Class for a flat pulse with k plateau samples inside the baseline
   function automatic logic is_n(input int k);
      longint bl, tl, m, s, f;
      bl = base;
      tl = top;
      m = ((32 - k) * bl + k * tl) >>> 5;
      s = (beta - alpha) * tl - beta * m;
      f = alpha * (tl - m);
      return s >= dl * (f <<< shft);
   endfunction : is_n
   // Random settings whose class does not hinge on the hit offset
   task automatic setup(input int cls);
      apb(1'b1, CCD_THR_OFS, 32'h0000_3FFF);
      do
      begin
         base = 14'($unsigned($random(seed)) % 200);
         top = base + 14'(400 + $unsigned($random(seed)) % 3000);
         alpha = 5 + $unsigned($random(seed)) % 2;
         beta = 90 + $unsigned($random(seed)) % 21;
         dl = 1 + $unsigned($random(seed)) % 20;
         shft = $unsigned($random(seed)) % 4;
         // Corner cases: 1 forces a sure neutron, 2 a sure gamma
         if (cls == 1)
         begin
            dl = 1;
            shft = 0;
         end
         else if (cls == 2)
         begin
            dl = 200;
            shft = 3;
         end
      end while (is_n(0) != is_n(1) || is_n(1) != is_n(2));
      apb(1'b1, CCD_ALPHA_OFS, 32'(alpha));
      apb(1'b1, CCD_BETA_OFS, 32'(beta));
      apb(1'b1, CCD_DELTA_OFS, 32'(dl));
      apb(1'b1, CCD_SHIFT_OFS, 32'(shft));
      repeat (40) @(posedge clk_in);
      apb(1'b1, CCD_THR_OFS, 32'(base) + 32'h4);
      repeat (40) @(posedge clk_in);
      n = is_n(0);
      fire <= 1'b1;
      @(posedge clk_in);
      fire <= 1'b0;
   endtask : setup
   // Shifts all six serial registers out, MSB first
   task automatic readout();
      @(posedge clk_in);
      pshift <= 1'b1;
      for (int i = 31; i >= 0; i--)
      begin
         @(negedge clk_in);
         for (int j = 0; j < 6; j++) lane[j][i] = ser[j];
         @(posedge clk_in);
      end
      pshift <= 1'b0;
   endtask : readout
   task automatic done(input string s);
      $display("test %s done", s);
   endtask : done
   // Verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      foreach (ofs[i])
      begin
         apb(1'b0, ofs[i], 32'h0);
         chk(rd, rst[i]);
      end
      apb(1'b0, 8'h24, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 8'h40, 32'h0000_FFFF);
      chk({31'h0, err}, 32'h1);
      done("registers");
      apb(1'b1, CCD_MASK_OFS, 32'h3);
      apb(1'b1, CCD_CTRL_OFS, 32'h1);
      for (int p = 0; p < 10; p++)
      begin
         setup(p < 2 ? p + 1 : 0);
         nexp += n;
         for (int k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clk_in);
         chk({31'h0, irq}, 32'h1);
         apb(1'b0, CCD_STAT_OFS, 32'h0);
         chk(rd, {30'h0, ~n, n});
         repeat (2) @(posedge clk_in);
         chk({31'h0, irq}, 32'h0);
         readout();
         chk(lane[0], 32'((beta - alpha) * top));
         chk(lane[1], 32'(alpha * top));
         // Baseline holds 31 flat samples and the crossing sample
         mb = (31 * base + top) >> 5;
         chk(lane[2], 32'(31 * base + top));
         chk(lane[3], 32'((beta - alpha) * top - beta * mb));
         chk(lane[4], 32'(alpha * (top - mb)));
         chk(lane[5], {8'(alpha), 8'(beta), 8'(dl), 4'h0, 4'(shft)});
         chk(32'(fired), 32'(nexp));
      end
      done("pulses");
      apb(1'b1, CCD_MASK_OFS, 32'h0);
      setup(0);
      nexp += n;
      repeat (300) @(posedge clk_in);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, CCD_STAT_OFS, 32'h0);
      chk(rd, {30'h0, ~n, n});
      done("masked");
      apb(1'b1, CCD_CTRL_OFS, 32'h0);
      setup(0);
      repeat (300) @(posedge clk_in);
      apb(1'b0, CCD_STAT_OFS, 32'h0);
      chk(rd, 32'h0);
      chk(32'(fired), 32'(nexp));
      apb(1'b0, CCD_COUNT_OFS, 32'h0);
      chk(rd, 32'(nexp));
      done("disabled");
      end_sim();
   end
   // Watchdog at about twelve times the expected run
   initial
   begin
      #(40 * 40000);
      bad_count++;
      end_sim();
   end
endmodule : testbench
